// >>> verilog/rrc_regs.svh
// Constants of the row/column readout control block
// Assumes inclusion by bare name from the design files
`ifndef RRC_REGS_SVH
`define RRC_REGS_SVH
`define RRC_ROWS 1024
`define RRC_COLS 1024
`define RRC_AW 10
`define RRC_DW 12
`define RRC_CAL_W 16
`define RRC_ADC_LAT 6
`define RRC_FIFO_D 16
`define RRC_NPIN 18
`define PIN_RD_ADV 0
`define PIN_RS_ADV 1
`define PIN_COL_CLK 2
`define PIN_CHOICE 3
`define PIN_ROW_RST 4
`define PIN_BLANK 5
`define PIN_SEL 6
`define PIN_BUS_A 7
`define PIN_SMP_R 8
`define PIN_SMP_S 9
`define PIN_CAL 10
`define PIN_CONV 11
`define PIN_SDIN 12
`define PIN_SLD 13
`define PIN_SCLK 14
`define PIN_RD_SYNC 15
`define PIN_RS_SYNC 16
`define PIN_COL_SYNC 17
`define MON_READ 2'h0
`define MON_RESET 2'h1
`define MON_COL 2'h2
`endif

// >>> verilog/rrc_pkg.sv
// Types of the row/column readout control block
// Assumes rrc_regs.svh is available on the include path
package rrc_pkg;
  typedef enum logic [1:0]
  {
    RRC_PH_FIRST = 2'b01,
    RRC_PH_SECOND = 2'b10
  } rrc_phase_e;
endpackage : rrc_pkg

// >>> verilog/rrc_readout.sv
// Row/column pointer control, converter pipeline and output FIFO
// Assumes all strobes arrive asynchronously from an external sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rrc_regs.svh"

// ------------------------------------------------------------
// Output FIFO
// ------------------------------------------------------------
module rrc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read accept
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rrc_fifo

// Contract
// [RL1] A read-row advance pulse moves the read-row pointer up one row.
// [RL2] A reset-row advance pulse moves the reset-row pointer up one row.
// [RL3] Column pointer advances once per two column-clock cycles.
// [RL4] Scan-end monitor shows the pointer chosen by the monitor selection.
// [RL5] Choice low addresses array by read-row pointer, high by reset-row.
// [RL6] Row reset resets the row of the enabled pointer.
// [RL7] Row select drives the enabled pointer's row onto column buses.
// [RL8] Controller holds blank high whenever no pixel readout happens.
// [RL9] Reset-level strobe samples selected row onto reset-level storage.
// [RL10] Signal-level strobe samples selected row onto signal-level storage.
// [RL11] Converter result appears 6.5 converter clocks after its sample.
// [RL12] Result is a 12-bit word, MSB on the highest data output.
// [RL13] Result LSB is on data output zero.
// [RL14] Calibration: serial data shifted by bit clock, then load strobe.
// [RL15] Array is 1024 rows by 1024 columns.
// [RL16] Row reset acts on the whole row at once.
// [RL17] Row select drives all 1024 columns at once.
// [RL18] Rows scan bottom to top, pixels left to right.
// [RL19] Each pointer is one-hot.
// [RL20] Sync strobes load each pointer from its start position.
// [RL21] Converter samples on rising edge, outputs six periods later, falling.
// [RL22] Scan-end monitor is high while selected pointer is at its last place.
module rrc_readout (
  input wire logic core_clk, // 125 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic read_row_advance, // Read-row advance pin
  input wire logic reset_row_advance, // Reset-row advance pin
  input wire logic column_advance_clk, // Column advance clock pin
  input wire logic row_pointer_choice, // 0 read-row, 1 reset-row
  input wire logic row_reset, // Row reset pin
  input wire logic blank, // Blanking pin
  input wire logic row_select, // Row select pin
  input wire logic column_bus_a, // Column bus pre-charge pin
  input wire logic reset_sample, // Reset-level sample pin
  input wire logic signal_sample, // Signal-level sample pin
  input wire logic pga_cal, // Amplifier calibrate pin
  input wire logic conv_clk, // Converter clock pin
  input wire logic [`RRC_DW-1:0] conv_in, // Digitised converter input
  input wire logic calib_din, // Calibration serial data
  input wire logic calib_load_strobe, // Calibration load strobe
  input wire logic calib_bit_clk, // Calibration bit clock
  input wire logic read_row_sync, // Read-row sync strobe
  input wire logic reset_row_sync, // Reset-row sync strobe
  input wire logic column_sync, // Column sync strobe
  input wire logic [`RRC_AW-1:0] row_start, // Row start position
  input wire logic [`RRC_AW-1:0] col_start, // Column start position
  input wire logic [1:0] monitor_sel, // Scan-end monitor selection
  output logic scan_end_monitor, // Scan-end monitor
  output logic [`RRC_ROWS-1:0] row_reset_lines, // Per-row reset lines
  output logic [`RRC_ROWS-1:0] row_select_lines, // Per-row select lines
  output logic [`RRC_COLS-1:0] column_select, // Column pointer
  output logic amp_reset_store, // Reset-level storage capture
  output logic amp_signal_store, // Signal-level storage capture
  output logic bus_column_bus_a, // Column bus pre-charge
  output logic pga_cal_en, // Amplifier calibrate
  output logic fill_ready, // FIFO can take a result
  output logic data_valid, // Data word valid
  input wire logic data_ready, // Downstream accepts word
  output logic [`RRC_DW-1:0] data_out, // Converter result
  output logic [`RRC_CAL_W-1:0] calib_word // Loaded calibration
);
  logic [`RRC_NPIN-1:0] pins;
  logic [`RRC_NPIN-1:0] s1_q;
  logic [`RRC_NPIN-1:0] s2_q;
  logic [`RRC_NPIN-1:0] s3_q;
  logic [`RRC_NPIN-1:0] lvl_q;
  logic [`RRC_NPIN-1:0] rise;
  logic [`RRC_NPIN-1:0] fall;
  logic [`RRC_ROWS-1:0] rd_ptr_q;
  logic [`RRC_ROWS-1:0] rs_ptr_q;
  logic [`RRC_COLS-1:0] col_ptr_q;
  logic [`RRC_ROWS-1:0] row_addr;
  rrc_pkg::rrc_phase_e phase_q;
  logic [`RRC_DW-1:0] pipe_q [`RRC_ADC_LAT+1];
  logic [`RRC_ADC_LAT:0] pv_q;
  logic push;
  logic [`RRC_DW-1:0] ff_data;
  logic ff_valid;
  logic ff_ready;
  logic [`RRC_CAL_W-1:0] shift_q;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [`RRC_ROWS-1:0] onehot(input logic [`RRC_AW-1:0] pos);
    onehot = '0;
    onehot[pos] = 1'b1;
  endfunction : onehot

  function automatic logic [`RRC_ROWS-1:0] step(input logic [`RRC_ROWS-1:0] p);
    step = {p[`RRC_ROWS-2:0], p[`RRC_ROWS-1]};
  endfunction : step

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  assign pins = {column_sync, reset_row_sync, read_row_sync, calib_bit_clk,
                 calib_load_strobe, calib_din, conv_clk, pga_cal, signal_sample,
                 reset_sample, column_bus_a, row_select, blank, row_reset,
                 row_pointer_choice, column_advance_clk, reset_row_advance,
                 read_row_advance};
  assign rise = s2_q & s3_q & ~lvl_q;
  assign fall = ~s2_q & ~s3_q & lvl_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  // ------------------------------------------------------------
  // Row pointers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_q <= `RRC_ROWS'(1);
      rs_ptr_q <= `RRC_ROWS'(1);
    end
    else
    begin
      if (rise[`PIN_RD_SYNC])
      begin
        rd_ptr_q <= onehot(row_start); // [RL20] [RL19]
      end
      else if (rise[`PIN_RD_ADV])
      begin
        rd_ptr_q <= step(rd_ptr_q); // [RL1] [RL18]
      end
      if (rise[`PIN_RS_SYNC])
      begin
        rs_ptr_q <= onehot(row_start); // [RL20]
      end
      else if (rise[`PIN_RS_ADV])
      begin
        rs_ptr_q <= step(rs_ptr_q); // [RL2] [RL18]
      end
    end
  end

  assign row_addr = lvl_q[`PIN_CHOICE] ? rs_ptr_q : rd_ptr_q; // [RL5]

  // ------------------------------------------------------------
  // Column pointer, one step per two column clocks
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_ptr_q <= `RRC_COLS'(1);
      phase_q <= rrc_pkg::RRC_PH_FIRST;
    end
    else if (rise[`PIN_COL_SYNC])
    begin
      col_ptr_q <= onehot(col_start); // [RL20] [RL15]
      phase_q <= rrc_pkg::RRC_PH_FIRST;
    end
    else if (rise[`PIN_COL_CLK])
    begin
      case (phase_q)
        rrc_pkg::RRC_PH_FIRST: phase_q <= rrc_pkg::RRC_PH_SECOND;
        rrc_pkg::RRC_PH_SECOND:
        begin
          phase_q <= rrc_pkg::RRC_PH_FIRST;
          col_ptr_q <= step(col_ptr_q); // [RL3] [RL18]
        end
        default: phase_q <= rrc_pkg::RRC_PH_FIRST;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Row drives, amplifier strobes, monitor
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_reset_lines <= '0;
      row_select_lines <= '0;
      amp_reset_store <= 1'b0;
      amp_signal_store <= 1'b0;
      bus_column_bus_a <= 1'b0;
      pga_cal_en <= 1'b0;
      scan_end_monitor <= 1'b0;
    end
    else
    begin
      row_reset_lines <= lvl_q[`PIN_ROW_RST] ? row_addr : '0; // [RL6] [RL16]
      row_select_lines <= lvl_q[`PIN_SEL] ? row_addr : '0; // [RL7] [RL17]
      amp_reset_store <= lvl_q[`PIN_SMP_R]; // [RL9]
      amp_signal_store <= lvl_q[`PIN_SMP_S]; // [RL10]
      bus_column_bus_a <= lvl_q[`PIN_BUS_A];
      pga_cal_en <= lvl_q[`PIN_CAL];
      case (monitor_sel)
        `MON_READ: scan_end_monitor <= rd_ptr_q[`RRC_ROWS-1]; // [RL4] [RL22]
        `MON_RESET: scan_end_monitor <= rs_ptr_q[`RRC_ROWS-1]; // [RL4]
        `MON_COL: scan_end_monitor <= col_ptr_q[`RRC_COLS-1]; // [RL4]
        default: scan_end_monitor <= 1'b0;
      endcase
    end
  end
  assign column_select = col_ptr_q;

  // ------------------------------------------------------------
  // Converter pipeline and output FIFO
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pv_q <= '0;
      for (int i = 0; i <= `RRC_ADC_LAT; i++)
      begin
        pipe_q[i] <= '0;
      end
    end
    else if (rise[`PIN_CONV])
    begin
      pipe_q[0] <= conv_in; // [RL21]
      pv_q <= {pv_q[`RRC_ADC_LAT-1:0], 1'b1}; // [RL11]
      for (int i = 1; i <= `RRC_ADC_LAT; i++)
      begin
        pipe_q[i] <= pipe_q[i-1]; // [RL11]
      end
    end
  end

  // Results taken during blanking, or before a real sample reaches the end, are discarded
  assign push = fall[`PIN_CONV] && pv_q[`RRC_ADC_LAT] && !lvl_q[`PIN_BLANK]; // [RL21] [RL8]

  rrc_fifo #(
    .WIDTH(`RRC_DW),
    .DEPTH(`RRC_FIFO_D)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fill_ready),
    .in_data(pipe_q[`RRC_ADC_LAT]),
    .out_valid(ff_valid),
    .out_ready(ff_ready),
    .out_data(ff_data)
  );

  assign ff_ready = !data_valid || data_ready;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_valid <= 1'b0;
      data_out <= '0;
    end
    else if (ff_ready)
    begin
      data_valid <= ff_valid;
      if (ff_valid)
      begin
        data_out <= ff_data; // [RL12] [RL13]
      end
    end
  end

  // ------------------------------------------------------------
  // Calibration serial upload
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= '0;
      calib_word <= '0;
    end
    else
    begin
      if (rise[`PIN_SCLK])
      begin
        shift_q <= {shift_q[`RRC_CAL_W-2:0], lvl_q[`PIN_SDIN]}; // [RL14]
      end
      if (rise[`PIN_SLD])
      begin
        calib_word <= shift_q; // [RL14]
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_read_adv: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL1]
    rise[`PIN_RD_ADV] && !rise[`PIN_RD_SYNC] |=> rd_ptr_q == step($past(rd_ptr_q)))
    else $error("read row pointer did not advance");
  a_reset_adv: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL2]
    rise[`PIN_RS_ADV] && !rise[`PIN_RS_SYNC] |=> rs_ptr_q == step($past(rs_ptr_q)))
    else $error("reset row pointer did not advance");
  a_col_half: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL3]
    rise[`PIN_COL_CLK] && phase_q == rrc_pkg::RRC_PH_FIRST && !rise[`PIN_COL_SYNC]
    |=> $stable(col_ptr_q))
    else $error("column moved on first clock");
  a_onehot_ptrs: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL19]
    $onehot(rd_ptr_q) && $onehot(rs_ptr_q) && $onehot(col_ptr_q))
    else $error("pointer not one-hot");
  a_row_choice: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL5]
    lvl_q[`PIN_SEL] && lvl_q[`PIN_CHOICE] |=> row_select_lines == $past(rs_ptr_q))
    else $error("select used wrong pointer");
  a_row_reset: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL6]
    lvl_q[`PIN_ROW_RST] && !lvl_q[`PIN_CHOICE] |=> row_reset_lines == $past(rd_ptr_q))
    else $error("reset used wrong row");
  a_sync_load: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL20]
    rise[`PIN_COL_SYNC] |=> col_ptr_q[$past(col_start)])
    else $error("column sync not loaded");
  a_scan_end: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL22]
    monitor_sel == `MON_COL && col_ptr_q[`RRC_COLS-1] |=> scan_end_monitor)
    else $error("scan end not flagged");
  a_adc_latency: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL11]
    rise[`PIN_CONV] |=> pipe_q[1] == $past(pipe_q[0]))
    else $error("converter pipeline stalled");
  a_cal_load: assert property (@(posedge core_clk) disable iff (!rst_n) // [RL14]
    rise[`PIN_SLD] |=> calib_word == $past(shift_q))
    else $error("calibration not loaded");
endmodule : rrc_readout
`default_nettype wire

// >>> verification/rrc_seq_model.sv
// Sequencer model that drives the readout block's strobe and level pins
// Assumes the pins are changed at the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
`include "rrc_regs.svh"

// ------------------------------------------------------------
// Strobe sequencer
// ------------------------------------------------------------
module rrc_seq_model (
  input wire logic core_clk, // Clock
  output logic [`RRC_NPIN-1:0] pins, // Strobe and level pins
  output logic [`RRC_DW-1:0] conv_in // Converter input word
);
  initial
  begin
    pins = '0;
    conv_in = 12'h000;
  end

  // Level change, held long enough to pass the pin synchroniser
  task automatic lvl(input int p, input logic v);
    @(negedge core_clk);
    pins[p] = v;
    repeat (5) @(negedge core_clk);
  endtask : lvl

  // One pulse, 4 cycles high then 5 low
  task automatic pulse(input int p);
    @(negedge core_clk);
    pins[p] = 1'b1;
    repeat (4) @(negedge core_clk);
    pins[p] = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask : pulse

  // Input word is valid only while the converter clock is high
  task automatic conv(input logic [`RRC_DW-1:0] v);
    @(negedge core_clk);
    conv_in = v;
    pins[`PIN_CONV] = 1'b1;
    repeat (4) @(negedge core_clk);
    pins[`PIN_CONV] = 1'b0;
    conv_in = ~v;
    repeat (5) @(negedge core_clk);
  endtask : conv

  // Serial upload, first bit ends up as the top bit, then load
  task automatic calib(input logic [`RRC_CAL_W-1:0] w);
    for (int i = `RRC_CAL_W - 1; i >= 0; i--)
    begin
      lvl(`PIN_SDIN, w[i]);
      pulse(`PIN_SCLK);
    end
    pins[`PIN_SDIN] = ~w[0];
    pulse(`PIN_SLD);
  endtask : calib
endmodule : rrc_seq_model
`default_nettype wire

// >>> verification/row_column_readout_control_test.sv
// Self-checking bench for the row/column readout control block
// Assumes rrc_seq_model drives all strobe pins of the block
`timescale 1ns/1ps
`default_nettype none
`include "rrc_regs.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module row_column_readout_control_test;
  logic core_clk;
  logic rst_n;
  logic data_ready;
  logic [1:0] monitor_sel;
  logic [`RRC_AW-1:0] row_start;
  logic [`RRC_AW-1:0] col_start;
  logic [`RRC_NPIN-1:0] pins;
  logic [`RRC_DW-1:0] conv_in;
  logic scan_end_monitor;
  logic [`RRC_ROWS-1:0] row_reset_lines;
  logic [`RRC_ROWS-1:0] row_select_lines;
  logic [`RRC_COLS-1:0] column_select;
  logic amp_reset_store, amp_signal_store, bus_column_bus_a, pga_cal_en;
  logic fill_ready, data_valid;
  logic [`RRC_DW-1:0] data_out;
  logic [`RRC_CAL_W-1:0] calib_word;
  int failures;
  int checks;

  rrc_seq_model M (.core_clk, .pins, .conv_in);

  rrc_readout DUT (
    .core_clk, .rst_n, .conv_in, .row_start, .col_start, .monitor_sel,
    .read_row_advance(pins[`PIN_RD_ADV]), .reset_row_advance(pins[`PIN_RS_ADV]),
    .column_advance_clk(pins[`PIN_COL_CLK]), .row_pointer_choice(pins[`PIN_CHOICE]),
    .row_reset(pins[`PIN_ROW_RST]), .blank(pins[`PIN_BLANK]), .row_select(pins[`PIN_SEL]),
    .column_bus_a(pins[`PIN_BUS_A]), .reset_sample(pins[`PIN_SMP_R]),
    .signal_sample(pins[`PIN_SMP_S]), .pga_cal(pins[`PIN_CAL]), .conv_clk(pins[`PIN_CONV]),
    .calib_din(pins[`PIN_SDIN]), .calib_load_strobe(pins[`PIN_SLD]),
    .calib_bit_clk(pins[`PIN_SCLK]), .read_row_sync(pins[`PIN_RD_SYNC]),
    .reset_row_sync(pins[`PIN_RS_SYNC]), .column_sync(pins[`PIN_COL_SYNC]),
    .scan_end_monitor, .row_reset_lines, .row_select_lines, .column_select,
    .amp_reset_store, .amp_signal_store, .bus_column_bus_a, .pga_cal_en,
    .fill_ready, .data_valid, .data_ready, .data_out, .calib_word
  );

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic t_reset();
    @(negedge core_clk);
    `CHK("column_select", 1024'h1, column_select)
    `CHK("row_select_lines", 1024'h0, row_select_lines)
    `CHK("data_valid", 1'b0, data_valid)
    `CHK("fill_ready", 1'b1, fill_ready)
    `CHK("calib_word", 16'h0000, calib_word)
    $display("test reset done");
  endtask : t_reset

  task automatic t_rows();
    repeat (3) M.pulse(`PIN_RD_ADV);
    repeat (2) M.pulse(`PIN_RS_ADV);
    M.lvl(`PIN_SEL, 1'b1);
    `CHK("read row", 1024'h1 << 3, row_select_lines)
    M.lvl(`PIN_CHOICE, 1'b1);
    `CHK("reset row", 1024'h1 << 2, row_select_lines)
    M.lvl(`PIN_SEL, 1'b0);
    M.lvl(`PIN_ROW_RST, 1'b1);
    `CHK("reset line", 1024'h1 << 2, row_reset_lines)
    `CHK("select idle", 1024'h0, row_select_lines)
    M.lvl(`PIN_CHOICE, 1'b0);
    `CHK("reset line rd", 1024'h1 << 3, row_reset_lines)
    M.lvl(`PIN_ROW_RST, 1'b0);
    row_start = 10'h3ff;
    M.pulse(`PIN_RD_SYNC);
    `CHK("scan end rd", 1'b1, scan_end_monitor)
    monitor_sel = `MON_RESET;
    repeat (2) @(negedge core_clk);
    `CHK("scan end rs", 1'b0, scan_end_monitor)
    M.pulse(`PIN_RS_SYNC);
    `CHK("scan end rs sync", 1'b1, scan_end_monitor)
    $display("test rows done");
  endtask : t_rows

  task automatic t_cols();
    repeat (4) M.pulse(`PIN_COL_CLK);
    `CHK("column two", 1024'h1 << 2, column_select)
    col_start = 10'h3ff;
    monitor_sel = `MON_COL;
    M.pulse(`PIN_COL_SYNC);
    `CHK("column sync", 1024'h1 << 1023, column_select)
    `CHK("scan end col", 1'b1, scan_end_monitor)
    monitor_sel = 2'h3;
    repeat (2) @(negedge core_clk);
    `CHK("scan end off", 1'b0, scan_end_monitor)
    monitor_sel = `MON_COL;
    repeat (2) M.pulse(`PIN_COL_CLK);
    `CHK("column wrap", 1024'h1, column_select)
    `CHK("scan end low", 1'b0, scan_end_monitor)
    $display("test columns done");
  endtask : t_cols

  task automatic t_amps();
    int p [4] = '{`PIN_SMP_R, `PIN_SMP_S, `PIN_BUS_A, `PIN_CAL};
    logic [3:0] seen;
    for (int i = 0; i < 4; i++)
    begin
      M.lvl(p[i], 1'b1);
      seen = {amp_reset_store, amp_signal_store, bus_column_bus_a, pga_cal_en};
      `CHK("amp strobes", 4'h8 >> i, seen)
      M.lvl(p[i], 1'b0);
    end
    $display("test amplifier strobes done");
  endtask : t_amps

  task automatic t_calib();
    M.calib(16'ha5c3);
    `CHK("calib_word", 16'ha5c3, calib_word)
    $display("test calibration done");
  endtask : t_calib

  task automatic t_conv();
    int n;
    int k;
    n = 0;
    while (n < 40 && !(n > 6 && fill_ready !== 1'b1))
    begin
      M.conv(12'h801 + n[11:0]);
      n++;
      if (n == 6)
        `CHK("early word", 1'b0, data_valid)
      if (n == 7)
        `CHK("first word", 12'h801, data_out)
    end
    if (n == 40)
    begin
      failures++;
      results();
    end
    `CHK("fifo depth", `RRC_FIFO_D + 1, n - 6)
    data_ready = 1'b1;
    k = 0;
    for (int c = 0; c < 100 && k < n - 6; c++)
    begin
      if (data_valid === 1'b1)
      begin
        `CHK("fifo word", 12'h801 + k[11:0], data_out)
        k++;
      end
      @(negedge core_clk);
    end
    `CHK("drained", n - 6, k)
    repeat (2) @(negedge core_clk);
    `CHK("empty", 1'b0, data_valid)
    `CHK("not full", 1'b1, fill_ready)
    $display("test converter done");
  endtask : t_conv

  task automatic t_blank();
    M.lvl(`PIN_BLANK, 1'b1);
    repeat (8) M.conv(12'hfff);
    `CHK("blank push", 1'b0, data_valid)
    M.lvl(`PIN_BLANK, 1'b0);
    $display("test blanking done");
  endtask : t_blank

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    data_ready = 1'b0;
    monitor_sel = `MON_READ;
    row_start = 10'h000;
    col_start = 10'h000;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_rows();
    t_cols();
    t_amps();
    t_calib();
    t_conv();
    t_blank();
    results();
  end
endmodule : row_column_readout_control_test
`default_nettype wire
